// [test/host_model.sv]
// Host-side model: chip select, clock pin resolution and word reader.
// Assumes the device samples clock mode at each chip select fall.
`timescale 1ns/1ps
module host_model (
    input  wire logic   core_clk,
    input  wire logic   sck_out,
    input  wire logic   sck_oe,
    input  wire logic   sck_pullup_en,
    input  wire logic   serial_out_pin,
    input  wire logic   serial_out_oe,
    output logic        cs_n,
    output logic        sck_wire,
    output logic        tail,
    output logic        hang,
    output logic [31:0] got
);
    logic host_oe = 1'b1, host_lvl = 1'b1, last_sck = 1'b1, last_dq = 1'b0, dq;
    event done_ev;

    initial begin
        cs_n = 1'b1;
        hang = 1'b0;
        tail = 1'b0;
        got = '0;
    end
    // device drives the pin in internal mode, else host or pull-up
    always_comb sck_wire = sck_oe ? sck_out : host_oe ? host_lvl : sck_pullup_en | ~last_sck;
    // Released data line shows no stale value
    always_comb dq = serial_out_oe ? serial_out_pin : ~last_dq;
    always @(posedge core_clk) begin
        last_sck <= sck_wire;
        last_dq <= dq;
    end

    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask

    task automatic wait_sck(input logic lvl);
        int n;
        // Last internal fall is the device releasing the pin to the pull-up
        for (n = 0; n < 400 && sck_wire !== lvl && (lvl || sck_oe === 1'b1); n++) tick();
        if (n == 400) hang = 1'b1;
    endtask

    task automatic read_word(input logic ext, input int nfall);
        int k;
        host_oe = 1'b1;
        repeat (3) begin
            host_lvl = 1'b0;
            repeat (2) tick();
            host_lvl = 1'b1;
            repeat (2) tick();
        end
        // mode level set up before chip select falls
        host_lvl = ext;
        tick();
        cs_n = 1'b0;
        repeat (2) tick();
        if (!ext) begin
            for (k = 0; k < 50 && sck_oe !== 1'b1; k++) tick();
            host_oe = 1'b0;
        end
        got = '0;
        for (k = 0; k < nfall; k++) begin
            if (ext) begin
                // sample in the high phase; the fall shifts
                got = {got[30:0], dq};
                host_lvl = 1'b0;
                repeat (3) tick();
                host_lvl = 1'b1;
                repeat (3) tick();
            end else begin
                wait_sck(1'b1);
                got = {got[30:0], dq};
                wait_sck(1'b0);
            end
        end
        repeat (3) tick();
        tail = dq;
        cs_n = 1'b1;
        host_oe = 1'b1;
        tick();
        if (nfall == 32) -> done_ev;
    endtask
endmodule

// [test/readout_monitor.sv]
// Checker on the sequencer's top ports.
// Assumes one core clock and the synchronous active-low rstn.
`timescale 1ns/1ps
module readout_monitor (
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire logic       supply_low,
    input wire logic       cs_n,
    input wire logic       sck_oe,
    input wire logic       sck_pullup_en,
    input wire logic       serial_out_pin,
    input wire logic       serial_out_oe,
    input wire logic       conv_busy,
    input wire logic       sleeping,
    input wire logic       data_out_active,
    input wire logic       int_sck_mode,
    input wire logic [1:0] cal_phase,
    input wire logic       por_busy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_cs_hiz: assert property (cs_n |-> !serial_out_oe)
        else $error("data pin driven while deselected");
    a_sleep_holds: assert property (sleeping && cs_n && !supply_low |=> sleeping)
        else $error("sleep left while deselected");
    a_one_state: assert property ($onehot({conv_busy, sleeping, data_out_active}))
        else $error("state bits not one-hot");
    a_sleep_entry: assert property ($rose(sleeping) |-> $past(conv_busy))
        else $error("sleep not entered from conversion");
    a_dout_entry: assert property ($rose(data_out_active) |-> $past(sleeping) && !$past(cs_n))
        else $error("output started without select in sleep");
    a_abort_conv: assert property (data_out_active && cs_n |=> conv_busy)
        else $error("deselect did not restart conversion");
    a_conv_source: assert property ($rose(conv_busy) |->
        $past(data_out_active) || $past(supply_low) || $past(por_busy))
        else $error("conversion started from wrong state");
    a_pullup_mode: assert property (sck_pullup_en == int_sck_mode)
        else $error("pull-up does not follow clock mode");
    a_sck_drive: assert property (sck_oe |-> int_sck_mode)
        else $error("clock pin driven in external mode");
    a_eoc_busy: assert property (conv_busy && $past(conv_busy) && $past(conv_busy, 2)
        && serial_out_oe |-> serial_out_pin)
        else $error("status low during conversion");
    a_eoc_done: assert property (sleeping && $past(sleeping) && serial_out_oe
        |-> !serial_out_pin)
        else $error("status high in sleep");
    a_brownout: assert property (supply_low |=> por_busy && conv_busy)
        else $error("low supply did not clear");
    a_por_quiet: assert property (por_busy |-> conv_busy && !serial_out_oe)
        else $error("activity during power-on clear");
    a_cal_in_conv: assert property (cal_phase != 2'h0 |-> conv_busy)
        else $error("calibration outside conversion");

    c_read: cover property ($rose(data_out_active));
    c_abort: cover property (data_out_active && cs_n);
    c_brown: cover property (supply_low);
    c_cal: cover property (cal_phase == 2'h2);
    c_int_read: cover property (sck_oe);
endmodule

// [test/testbench.sv]
// Bench: results pushed into the stream, host model reads them serially.
// Assumes short counts set through the sequencer's parameters.
`timescale 1ns/1ps
module testbench;
    logic        core_clk, rstn, supply_low, notch_freq_select_pin, sample_valid;
    logic [31:0] sample_word, w;
    wire         cs_n, sck_in, sck_out, sck_oe, sck_pullup_en, serial_out_pin, serial_out_oe;
    wire         sample_ready, conv_busy, sleeping, data_out_active, ext_clk_mode;
    wire         int_sck_mode, por_busy, tail, hang;
    wire  [31:0] got;
    logic [31:0] exp_q[$];
    int          miscompares = 0, n_compared = 0, i;

    adc_conversion_serial_readout #(.POR_CYCLES(32'd20), .CONV_CYC_50(32'd200),
        .CONV_CYC_60(32'd160), .EXT_CONV_EDGES(32'd8), .EXT_DET_CYCLES(32'd64))
        dut (.core_clk, .rstn, .supply_low, .cs_n, .sck_in, .sck_out,
        .sck_oe, .sck_pullup_en, .serial_out_pin, .serial_out_oe, .notch_freq_select_pin,
        .sample_word, .sample_valid, .sample_ready, .conv_busy, .sleeping, .data_out_active,
        .ext_clk_mode, .int_sck_mode, .cal_phase(), .por_busy);

    host_model host (.core_clk, .sck_out, .sck_oe, .sck_pullup_en, .serial_out_pin,
        .serial_out_oe, .cs_n, .sck_wire(sck_in), .tail, .hang, .got);

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wait_state(input logic por);
        int n;
        for (n = 0; n < 3000 && (por ? por_busy !== 1'b0 : sleeping !== 1'b1); n++) tick();
        if (n == 3000) begin
            miscompares++;
            wrap_up();
        end
    endtask

    // Each delivered word against the oldest note
    always @(host.done_ev) begin
        check(got, exp_q.pop_front());
        check({31'h0, tail}, 32'h1);
    end

    initial begin
        rstn = 1'b0;
        supply_low = 1'b0;
        notch_freq_select_pin = 1'b1;
        sample_valid = 1'b0;
        sample_word = '0;
        void'($urandom(32'h4287));
        repeat (8) @(posedge core_clk);
        #1 rstn = 1'b1;
        wait_state(1'b1);
        check({31'h0, int_sck_mode}, 32'h0);
        for (i = 0; i < 8; i++) begin
            w = {2'b00, 30'($urandom())};
            if (i == 1) w[31] = 1'b1;
            if (i == 2) w[30] = 1'b1;
            sample_word = w;
            sample_valid = 1'b1;
            // range flags give fixed codes; word 5 is abandoned
            if (i != 5)
                exp_q.push_back(w[31] ? 32'h30000000 : w[30] ? 32'h0fffffff : {2'b00, w[29:0]});
            tick();
        end
        sample_valid = 1'b0;
        check({31'h0, sample_ready}, 32'h0);
        for (i = 0; i < 8; i++) begin
            notch_freq_select_pin = i[1];
            wait_state(1'b0);
            // result kept through a long sleep
            if (i == 3) repeat (300) tick();
            host.read_word(i[0], i == 5 ? 5 : 32);
            tick();
            if (i == 5) check({31'h0, conv_busy}, 32'h1);
        end
        check({31'h0, sample_ready}, 32'h1);
        check({31'h0, ext_clk_mode}, 32'h0);
        check({31'h0, hang}, 32'h0);
        check(exp_q.size(), 32'h0);
        supply_low = 1'b1;
        tick();
        supply_low = 1'b0;
        tick();
        check({31'h0, por_busy}, 32'h1);
        wait_state(1'b1);
        check({31'h0, conv_busy}, 32'h1);
        wrap_up();
    end
endmodule

bind adc_conversion_serial_readout readout_monitor mon (.core_clk, .rstn, .supply_low, .cs_n,
    .sck_oe, .sck_pullup_en, .serial_out_pin, .serial_out_oe, .conv_busy, .sleeping,
    .data_out_active, .int_sck_mode, .cal_phase, .por_busy);

// [verilog/adc_conversion_serial_readout.v]
// Digital sequencer of a delta-sigma converter with 3-wire serial readout.
// Assumes all pins are synchronous to core_clk; results arrive on a
// valid/ready stream from the filter and wait in a small FIFO.
`timescale 1ns/1ps
`include "adc_readout_defines.vh"
module adc_conversion_serial_readout #(
    parameter [31:0] POR_CYCLES     = `POR_TIME_US * `CLK_MHZ,
    parameter [31:0] CONV_CYC_50    = `CLK_HZ / `NULL_50_HZ,
    parameter [31:0] CONV_CYC_60    = `CLK_HZ / `NULL_60_HZ,
    parameter [31:0] EXT_CONV_EDGES = `EXT_CLKS_PER_NULL,
    parameter [31:0] EXT_DET_CYCLES = `CLK_HZ / `EXT_MIN_HZ,
    parameter [15:0] SCK_HALF       = (`INT_SCK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter        FIFO_DEPTH     = `FIFO_DEPTH,
    parameter        FIFO_AW        = 3
) (
    input  wire        core_clk,
    input  wire        rstn,
    input  wire        supply_low,
    input  wire        cs_n,
    input  wire        sck_in,
    output wire        sck_out,
    output wire        sck_oe,
    output wire        sck_pullup_en,
    output wire        serial_out_pin,
    output wire        serial_out_oe,
    input  wire        notch_freq_select_pin,
    input  wire [31:0] sample_word,
    input  wire        sample_valid,
    output wire        sample_ready,
    output wire        conv_busy,
    output wire        sleeping,
    output wire        data_out_active,
    output wire        ext_clk_mode,
    output wire        int_sck_mode,
    output reg  [1:0]  cal_phase,
    output wire        por_busy
);
    reg  [31:0] por_cnt_r;
    reg  [2:0]  st_r;
    reg         cs_prev_r;
    reg         sck_prev_r;
    reg         f0_prev_r;
    reg         int_sck_r;
    reg  [31:0] ext_tmr_r;
    reg  [31:0] conv_cnt_r;
    reg  [31:0] conv_lim_r;
    reg  [31:0] sr_r;
    reg  [5:0]  bit_cnt_r;
    reg         out_r;
    reg  [15:0] div_cnt_r;
    reg         sck_gen_r;
    reg  [2:0]  st_nxt;

    wire        rst;
    wire        cs_fall;
    wire        f0_rise;
    wire        ext_fall;
    wire        gen_wrap;
    wire        gen_fall;
    wire        sh_fall;
    wire        last_bit;
    wire        ext_mode;
    wire [31:0] lim;
    wire        count_done;
    wire        start_conv;
    wire        conv_finish;
    wire        in_dout;
    wire [31:0] fifo_data;
    wire        fifo_valid;
    wire        fifo_ready;
    wire [31:0] cal_off_start;
    wire [31:0] cal_fs_start;

    // Result word in the order it leaves the pin, EOC first
    function [31:0] fmt_word;
        input [31:0] w;
        begin
            if (w[`IN_OVER_BIT]) begin
                fmt_word = `OVER_CODE;
            end else if (w[`IN_UNDER_BIT]) begin
                fmt_word = `UNDER_CODE;
            end else begin
                fmt_word = {2'b00, w[`IN_SIGN_BIT], w[`CODE_MSB:0]};
            end
        end
    endfunction

    always @(posedge core_clk) begin
        if (!rstn || supply_low) begin
            por_cnt_r <= POR_CYCLES;
        end else if (por_cnt_r != 32'h0) begin
            por_cnt_r <= por_cnt_r - 32'h1;
        end
    end

    assign por_busy = (por_cnt_r != 32'h0);
    assign rst      = por_busy;

    assign cs_fall  = cs_prev_r & ~cs_n;
    assign f0_rise  = ~f0_prev_r & notch_freq_select_pin;
    assign ext_fall = sck_prev_r & ~sck_in;
    assign in_dout  = (st_r == `ST_DOUT);

    always @(posedge core_clk) begin
        if (rst) begin
            cs_prev_r  <= 1'b1;
            sck_prev_r <= 1'b1;
            f0_prev_r  <= notch_freq_select_pin;
        end else begin
            cs_prev_r  <= cs_n;
            sck_prev_r <= sck_in;
            f0_prev_r  <= notch_freq_select_pin;
        end
    end

    // Clock mode taken at power-up and each chip select fall
    always @(posedge core_clk) begin
        if (!rstn || supply_low) begin
            int_sck_r <= 1'b0;
        end else if (por_cnt_r == 32'h1) begin
            int_sck_r <= (sck_in == `INT_SCK_LEVEL);
        end else if (!rst && cs_fall) begin
            int_sck_r <= (sck_in == `INT_SCK_LEVEL);
        end
    end

    // Edges on the notch pin select the external clock
    always @(posedge core_clk) begin
        if (rst) begin
            ext_tmr_r <= 32'h0;
        end else if (f0_rise) begin
            ext_tmr_r <= EXT_DET_CYCLES;
        end else if (ext_tmr_r != 32'h0) begin
            ext_tmr_r <= ext_tmr_r - 32'h1;
        end
    end

    assign ext_mode = (ext_tmr_r != 32'h0);

    // Internal clock generator for the data output state
    always @(posedge core_clk) begin
        if (rst || !in_dout || !int_sck_r || cs_n) begin
            div_cnt_r <= 16'h0;
            sck_gen_r <= 1'b0;
        end else if (gen_wrap) begin
            div_cnt_r <= 16'h0;
            sck_gen_r <= ~sck_gen_r;
        end else begin
            div_cnt_r <= div_cnt_r + 16'h1;
        end
    end

    assign gen_wrap = (div_cnt_r == SCK_HALF - 16'h1);
    assign gen_fall = gen_wrap & sck_gen_r;

    // Pin driven only in internal mode during data output
    assign sck_out       = sck_gen_r;
    assign sck_oe        = int_sck_r & in_dout & ~cs_n & ~rst;
    assign sck_pullup_en = int_sck_r;

    // Falling clock edges count only in data output with chip select low
    assign sh_fall  = in_dout & ~cs_n & (int_sck_r ? gen_fall : ext_fall);
    assign last_bit = (bit_cnt_r == `LAST_BIT_IDX);

    // Internal oscillator length set by notch pin level
    // External clock counts its own edges
    assign lim        = ext_mode ? EXT_CONV_EDGES : conv_lim_r;
    assign count_done = (conv_cnt_r >= lim);
    // Chip select high in data output restarts conversion
    assign start_conv = in_dout & (cs_n | (sh_fall & last_bit));
    assign fifo_ready = (st_r == `ST_CONV) & count_done & ~rst;
    assign conv_finish = fifo_ready & fifo_valid;

    always @(posedge core_clk) begin
        if (rst || start_conv) begin
            conv_cnt_r <= 32'h0;
            conv_lim_r <= notch_freq_select_pin ? CONV_CYC_50 : CONV_CYC_60;
        end else if ((st_r == `ST_CONV) && !count_done) begin
            if (!ext_mode || f0_rise) begin
                conv_cnt_r <= conv_cnt_r + 32'h1;
            end
        end
    end

    // Calibration slots inside the conversion window
    assign cal_off_start = lim - (lim >> 2);
    assign cal_fs_start  = lim - (lim >> 3);

    always @* begin
        if (st_r != `ST_CONV) begin
            cal_phase = `PH_MEASURE;
        end else if (conv_cnt_r >= cal_fs_start) begin
            cal_phase = `PH_FULLSCALE;
        end else if (conv_cnt_r >= cal_off_start) begin
            cal_phase = `PH_OFFSET;
        end else begin
            cal_phase = `PH_MEASURE;
        end
    end

    always @* begin
        st_nxt = st_r;
        case (st_r)
            `ST_CONV: begin
                if (conv_finish) begin
                    st_nxt = `ST_SLEEP;
                end
            end
            `ST_SLEEP: begin
                if (!cs_n) begin
                    st_nxt = `ST_DOUT;
                end
            end
            `ST_DOUT: begin
                if (start_conv) begin
                    st_nxt = `ST_CONV;
                end
            end
            default: begin
                st_nxt = `ST_CONV;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (rst) begin
            st_r <= `ST_CONV;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Shift register and output bit
    always @(posedge core_clk) begin
        if (rst) begin
            sr_r      <= 32'h0;
            bit_cnt_r <= 6'h0;
            out_r     <= 1'b1;
        end else begin
            case (st_r)
                `ST_CONV: begin
                    bit_cnt_r <= 6'h0;
                    if (conv_finish) begin
                        // Word of the conversion just done
                        sr_r  <= fmt_word(fifo_data);
                        out_r <= 1'b0;
                    end else begin
                        out_r <= 1'b1;
                    end
                end
                `ST_SLEEP: begin
                    out_r     <= sr_r[`WORD_BITS-1];
                    bit_cnt_r <= 6'h0;
                end
                `ST_DOUT: begin
                    if (cs_n) begin
                        out_r <= 1'b1;
                    end else if (sh_fall) begin
                        if (last_bit) begin
                            // Line high marks the new conversion
                            out_r <= 1'b1;
                        end else begin
                            out_r     <= sr_r[`WORD_BITS-2];
                            sr_r      <= {sr_r[`WORD_BITS-2:0], 1'b0};
                            bit_cnt_r <= bit_cnt_r + 6'h1;
                        end
                    end
                end
                default: begin
                    out_r <= 1'b1;
                end
            endcase
        end
    end

    // Pin released whenever chip select is high
    // Status visible with chip select low
    assign serial_out_pin  = out_r;
    assign serial_out_oe   = ~cs_n & ~rst;

    assign conv_busy       = st_r[0];
    assign sleeping        = st_r[1];
    assign data_out_active = st_r[2];
    assign ext_clk_mode    = ext_mode;
    assign int_sck_mode    = int_sck_r;

    result_fifo #(
        .WIDTH (`WORD_BITS),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_data   (sample_word),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready)
    );
endmodule

// [verilog/adc_readout_defines.vh]
// Constants for the converter sequencer and its serial readout.
// Assumes a single 125 MHz core clock and a synchronous active-low reset.
// Behaviour
// - After conversion, sleep in low power while chip select stays high.
// - Chip select rising during data output aborts it and starts conversion.
// - Chip select high keeps the serial data pin undriven.
// - In conversion and sleep, chip select low shows conversion status.
// - Internal mode drives serial clock; external mode takes it as input.
// - Internal serial clock mode enables the weak pull-up on the clock pin.
// - Clock mode sampled from clock pin at power-up or chip select fall.
// - Notch pin high gives 50Hz null, low gives 60Hz, internal oscillator.
// - Clock on notch pin becomes system clock; null at frequency over 2560.
// - States cycle conversion, sleep, data output, then conversion again.
// - Sleep keeps the finished result unchanged in the shift register.
// - Chip select low outputs the result of the conversion just finished.
// - Data changes on falling clock edges; host samples on rising edges.
// - Data output ends after 32 bits or chip select high; conversion restarts.
// - Modes come only from pin timing and never alter the state cycle.
// - Offset and full-scale calibration run inside each conversion unseen.
// - Low supply holds the device in internal reset.
// - Supply recovery gives about 1ms power-on clear, then a conversion.
// - Inputs beyond full scale give distinct overrange or underrange codes.
// - First output bit is high during conversion, low once complete.
// - 32nd falling clock edge drives data high, marking a new conversion.
// - Clock pulses are ignored while chip select is high.
`ifndef ADC_READOUT_DEFINES_VH
`define ADC_READOUT_DEFINES_VH

`define CLK_HZ            125000000
`define CLK_MHZ           125
`define CLK_PERIOD_NS     8
`define POR_TIME_US       1000
`define NULL_50_HZ        50
`define NULL_60_HZ        60
`define EXT_CLKS_PER_NULL 2560
`define EXT_MIN_HZ        2560
`define INT_SCK_HALF_NS   1000
`define INT_SCK_LEVEL     1'b0

`define ST_CONV           3'h1
`define ST_SLEEP          3'h2
`define ST_DOUT           3'h4

`define WORD_BITS         32
`define LAST_BIT_IDX      6'h1f
`define IN_OVER_BIT       31
`define IN_UNDER_BIT      30
`define IN_SIGN_BIT       29
`define CODE_MSB          28
`define OVER_CODE         32'h30000000
`define UNDER_CODE        32'h0fffffff
`define FIFO_DEPTH        8

`define PH_MEASURE        2'h0
`define PH_OFFSET         2'h1
`define PH_FULLSCALE      2'h2

`endif

// [verilog/result_fifo.v]
// Synchronous FIFO holding conversion results ahead of the sequencer.
// Assumes one clock; depth is a power of two.
`timescale 1ns/1ps
module result_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             core_clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output reg  [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_r;
    reg [AW-1:0]    rd_ptr_r;
    reg [AW:0]      count_r;
    wire            push;
    wire            pop;

    assign in_ready  = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @* begin
        out_data = mem[rd_ptr_r];
    end

    always @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push & ~pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop & ~push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule
